// ---- src/bridge_audio_clock_config.sv ----
// register bank for audio word clock sampling, audio split, 3d and clocking
// assumes synchronous inputs and a single 10 MHz clock
`timescale 1ns/1ns

module bridge_audio_clock_config
(
  input  wire logic                               clk,
  input  wire logic                               reset,
  input  wire bridge_audio_clock_pkg::reg_req_s   req,
  output logic [7:0]                              rdata,
  input  wire logic                               mode_strap_pin,
  input  wire bridge_audio_clock_pkg::tx_mode_e   tx_mode,
  input  wire logic                               independent_mode,
  input  wire logic                               selected_port,
  input  wire logic                               continuous_clock_set,
  output logic                                    secondary_word_clock_edge,
  output bridge_audio_clock_pkg::audio_route_s    audio_route,
  output logic                                    side_by_side_3d_enable,
  output logic                                    dual_input_left_right_enable,
  output bridge_audio_clock_pkg::clk_src_e        port0_clk_src,
  output bridge_audio_clock_pkg::clk_src_e        port1_clk_src,
  output logic                                    clk_mode_error
);

  logic       wc_edge;
  logic       audio_split;
  logic       strap_done;
  logic [7:0] cfg_two;
  logic [1:0] mode_p0;
  logic [1:0] mode_p1;
  logic [7:0] next_rdata;

  function automatic bridge_audio_clock_pkg::clk_src_e
    src_of(input logic [1:0] mode, input logic port);
    unique case (mode)
      2'b00: src_of = bridge_audio_clock_pkg::src_input_clock;
      2'b01: src_of = bridge_audio_clock_pkg::src_ref_pin_0;
      2'b10: src_of = bridge_audio_clock_pkg::src_internal_osc;
      2'b11: src_of = port ? bridge_audio_clock_pkg::src_ref_pin_1
                           : bridge_audio_clock_pkg::src_ref_pin_0;
    endcase
  endfunction

  wire wr_audio = req.write && req.addr ==
                  bridge_audio_clock_pkg::audio_config_addr;
  wire wr_two   = req.write && req.addr ==
                  bridge_audio_clock_pkg::bridge_config_two_addr;

  ////////////////////////////////////////////////////////////////////////
  // audio config

  always_ff @(posedge clk)
  begin
    if (reset)
      wc_edge <= bridge_audio_clock_pkg::wc_edge_rst;
    else if (wr_audio)
      wc_edge <= req.wdata[bridge_audio_clock_pkg::wc_edge_bit];
  end

  // strap caught on first edge after reset release
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      strap_done  <= 1'b0;
      audio_split <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_done  <= 1'b1;
      audio_split <= mode_strap_pin;
    end
    else if (wr_audio)
      audio_split <= req.wdata[bridge_audio_clock_pkg::split_bit];
  end

  ////////////////////////////////////////////////////////////////////////
  // bridge config two, clock mode kept per port

  always_ff @(posedge clk)
  begin
    if (reset)
      cfg_two <= bridge_audio_clock_pkg::bridge_config_two_rst;
    else if (wr_two)
      cfg_two <= req.wdata & bridge_audio_clock_pkg::bridge_config_two_mask;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_p0 <= 2'b00;
      mode_p1 <= 2'b00;
    end
    else if (wr_two)
    begin
      if (!independent_mode || !selected_port)
        mode_p0 <= req.wdata[bridge_audio_clock_pkg::clk_mode_lsb +: 2];
      if (!independent_mode || selected_port)
        mode_p1 <= req.wdata[bridge_audio_clock_pkg::clk_mode_lsb +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port

  always_comb
  begin
    next_rdata = 8'h00;
    if (req.read)
    begin
      if (req.addr == bridge_audio_clock_pkg::audio_config_addr)
      begin
        next_rdata[bridge_audio_clock_pkg::wc_edge_bit] = wc_edge;
        next_rdata[bridge_audio_clock_pkg::split_bit]   = audio_split;
      end
      else if (req.addr == bridge_audio_clock_pkg::bridge_config_two_addr)
      begin
        next_rdata    = cfg_two;
        next_rdata[bridge_audio_clock_pkg::clk_mode_lsb +: 2] =
          (independent_mode && selected_port) ? mode_p1 : mode_p0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rdata <= 8'h00;
    else
      rdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  logic split_active;
  assign split_active = audio_split &&
    (tx_mode == bridge_audio_clock_pkg::tx_replicate ||
     tx_mode == bridge_audio_clock_pkg::tx_splitter);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      audio_route <= '0;
      secondary_word_clock_edge    <= 1'b0;
      side_by_side_3d_enable       <= 1'b0;
      dual_input_left_right_enable <= 1'b0;
      port0_clk_src  <= bridge_audio_clock_pkg::src_input_clock;
      port1_clk_src  <= bridge_audio_clock_pkg::src_input_clock;
      clk_mode_error <= 1'b0;
    end
    else
    begin
      secondary_word_clock_edge <= wc_edge;
      if (split_active)
        audio_route <= '{port0_lines: 2'b01, port1_lines: 2'b10};
      else
        audio_route <= '{port0_lines: 2'b11, port1_lines: 2'b11};
      side_by_side_3d_enable <=
        cfg_two[bridge_audio_clock_pkg::sbs_3d_bit];
      dual_input_left_right_enable <=
        cfg_two[bridge_audio_clock_pkg::dual_lr_bit];
      port0_clk_src <= src_of(mode_p0, 1'b0);
      port1_clk_src <= src_of(mode_p1, 1'b1);
      clk_mode_error <=
        ((mode_p0 == 2'b11 || mode_p1 == 2'b11) && !independent_mode) ||
        (mode_p0 == 2'b00 && !continuous_clock_set);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_swc_follow;
    @(posedge clk) disable iff (reset)
      wr_audio ##1 1 |=> secondary_word_clock_edge ==
        $past(req.wdata[bridge_audio_clock_pkg::wc_edge_bit], 2);
  endproperty
  a_swc_follow: assert property (p_swc_follow)
    else $error("edge bit not applied");

  property p_split_route;
    @(posedge clk) disable iff (reset)
      split_active |=> audio_route.port0_lines == 2'b01 &&
                       audio_route.port1_lines == 2'b10;
  endproperty
  a_split_route: assert property (p_split_route)
    else $error("split routing wrong");

  property p_full_route;
    @(posedge clk) disable iff (reset)
      !audio_split |=> audio_route == 4'hf;
  endproperty
  a_full_route: assert property (p_full_route)
    else $error("unsplit routing wrong");

  property p_single_dual;
    @(posedge clk) disable iff (reset)
      (tx_mode == bridge_audio_clock_pkg::tx_single ||
       tx_mode == bridge_audio_clock_pkg::tx_dual) |=> audio_route == 4'hf;
  endproperty
  a_single_dual: assert property (p_single_dual)
    else $error("split acted in single or dual mode");

  property p_strap;
    @(posedge clk) $fell(reset) |=> audio_split == $past(mode_strap_pin);
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap not loaded");

  property p_sbs;
    @(posedge clk) disable iff (reset)
      wr_two ##2 !$past(wr_two) |-> side_by_side_3d_enable ==
        $past(req.wdata[7], 2);
  endproperty
  a_sbs: assert property (p_sbs)
    else $error("3d enable not applied");

  property p_lr;
    @(posedge clk) disable iff (reset)
      wr_two ##2 !$past(wr_two) |-> dual_input_left_right_enable ==
        $past(req.wdata[6], 2);
  endproperty
  a_lr: assert property (p_lr)
    else $error("left right enable not applied");

  property p_indep;
    @(posedge clk) disable iff (reset)
      wr_two && independent_mode && !selected_port |=> $stable(mode_p1);
  endproperty
  a_indep: assert property (p_indep)
    else $error("unselected port mode changed");

  property p_reserved;
    @(posedge clk) disable iff (reset)
      $past(req.read) |->
        (($past(req.addr) == bridge_audio_clock_pkg::audio_config_addr) ?
           (rdata & ~bridge_audio_clock_pkg::audio_config_mask) == 8'h00 :
         ($past(req.addr) ==
          bridge_audio_clock_pkg::bridge_config_two_addr) ?
           (rdata & ~bridge_audio_clock_pkg::bridge_config_two_mask) ==
             8'h00 :
           rdata == 8'h00);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits not zero");

  property p_clk_err;
    @(posedge clk) disable iff (reset)
      mode_p0 == bridge_audio_clock_pkg::clk_input_ref &&
      !continuous_clock_set |=> clk_mode_error;
  endproperty
  a_clk_err: assert property (p_clk_err)
    else $error("mode 00 without continuous clock not flagged");

  property p_ext_ref;
    @(posedge clk) disable iff (reset)
      mode_p0 == bridge_audio_clock_pkg::clk_external_ref |=>
        port0_clk_src == bridge_audio_clock_pkg::src_ref_pin_0;
  endproperty
  a_ext_ref: assert property (p_ext_ref)
    else $error("external reference not selected");

  property p_internal;
    @(posedge clk) disable iff (reset)
      mode_p1 == bridge_audio_clock_pkg::clk_internal_ref |=>
        port1_clk_src == bridge_audio_clock_pkg::src_internal_osc;
  endproperty
  a_internal: assert property (p_internal)
    else $error("internal clock not selected");

  property p_dual_ext;
    @(posedge clk) disable iff (reset)
      mode_p1 == bridge_audio_clock_pkg::clk_dual_ext_ref |=>
        port1_clk_src == bridge_audio_clock_pkg::src_ref_pin_1;
  endproperty
  a_dual_ext: assert property (p_dual_ext)
    else $error("port 1 not on its own reference pin");

  c_split: cover property (@(posedge clk) split_active);
  c_mode3: cover property (@(posedge clk) mode_p0 == 2'b11 &&
                           independent_mode);
  c_sbs:   cover property (@(posedge clk) side_by_side_3d_enable);
  c_lr:    cover property (@(posedge clk) dual_input_left_right_enable);
  c_err:   cover property (@(posedge clk) clk_mode_error);

endmodule

// ---- src/bridge_audio_clock_pkg.sv ----
// constants and carriers for the audio/clock configuration bank
// assumes a byte-wide register port with the offsets fixed below
package bridge_audio_clock_pkg;

  localparam logic [7:0] audio_config_addr      = 8'h55;
  localparam logic [7:0] bridge_config_two_addr = 8'h56;

  // audio_config fields
  localparam int wc_edge_bit    = 5;
  localparam int split_bit      = 4;
  localparam logic [7:0] audio_config_mask      = 8'h30;
  // bridge_config_two fields
  localparam int sbs_3d_bit     = 7;
  localparam int dual_lr_bit    = 6;
  localparam int clk_mode_lsb   = 0;
  localparam logic [7:0] bridge_config_two_mask = 8'hc3;
  localparam logic [7:0] bridge_config_two_rst  = 8'h00;
  localparam logic       wc_edge_rst            = 1'b0;

  typedef enum logic [1:0] {
    clk_input_ref    = 2'b00,
    clk_external_ref = 2'b01,
    clk_internal_ref = 2'b10,
    clk_dual_ext_ref = 2'b11
  } clk_mode_e;

  typedef enum logic [1:0] {
    tx_single    = 2'b00,
    tx_dual      = 2'b01,
    tx_replicate = 2'b10,
    tx_splitter  = 2'b11
  } tx_mode_e;

  typedef enum logic [1:0] {
    src_input_clock   = 2'b00,
    src_ref_pin_0     = 2'b01,
    src_ref_pin_1     = 2'b10,
    src_internal_osc  = 2'b11
  } clk_src_e;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [1:0] port0_lines;  // which lines on port 0 (bit0 a/b, bit1 c/d)
    logic [1:0] port1_lines;
  } audio_route_s;

endpackage

// ---- test/bridge_audio_clock_config_tb.sv ----
// self-checking bench for the audio/clock configuration bank
// assumes the bank at 0x55/0x56 and a one-cycle read latency
`timescale 1ns/1ns
module bridge_audio_clock_config_tb;
  logic                                 clk;
  logic                                 reset;
  bridge_audio_clock_pkg::reg_req_s     req;
  logic [7:0]                           rdata;
  logic                                 mode_strap_pin;
  bridge_audio_clock_pkg::tx_mode_e     tx_mode;
  logic                                 independent_mode;
  logic                                 selected_port;
  logic                                 continuous_clock_set;
  logic                                 wc_edge;
  bridge_audio_clock_pkg::audio_route_s audio_route;
  logic                                 sbs_3d;
  logic                                 dual_lr;
  bridge_audio_clock_pkg::clk_src_e     port0_clk_src;
  bridge_audio_clock_pkg::clk_src_e     port1_clk_src;
  logic                                 clk_mode_error;
  int                                   failures;
  int                                   compares;
  int                                   i;
  logic [7:0]                           exp_src [3];
  //////////////////////////////////////////////////////////////////////////
  bridge_audio_clock_config dut_u
  (
    .clk                          (clk),
    .reset                        (reset),
    .req                          (req),
    .rdata                        (rdata),
    .mode_strap_pin               (mode_strap_pin),
    .tx_mode                      (tx_mode),
    .independent_mode             (independent_mode),
    .selected_port                (selected_port),
    .continuous_clock_set         (continuous_clock_set),
    .secondary_word_clock_edge    (wc_edge),
    .audio_route                  (audio_route),
    .side_by_side_3d_enable       (sbs_3d),
    .dual_input_left_right_enable (dual_lr),
    .port0_clk_src                (port0_clk_src),
    .port1_clk_src                (port1_clk_src),
    .clk_mode_error               (clk_mode_error)
  );
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset(input logic strap);
    mode_strap_pin <= strap;
    reset          <= 1'b1;
    repeat (5) @(posedge clk);
    reset          <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req.write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req.read <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // audio fields, strap load, routing per transmit mode
  task automatic t_audio();
    logic [7:0] d;
    do_reset(1'b1);
    rd(8'h55, d);
    chk(d, 8'h10);
    wr(8'h55, 8'hff);
    rd(8'h55, d);
    chk(d, 8'h30);
    @(posedge clk);
    tx_mode <= bridge_audio_clock_pkg::tx_replicate;
    settle();
    chk(wc_edge, 8'h01);
    chk(audio_route, 8'h06);
    @(posedge clk);
    tx_mode <= bridge_audio_clock_pkg::tx_splitter;
    settle();
    chk(audio_route, 8'h06);
    wr(8'h55, 8'h00);
    settle();
    chk(audio_route, 8'h0f);
    chk(wc_edge, 8'h00);
    wr(8'h55, 8'h10);
    tx_mode <= bridge_audio_clock_pkg::tx_single;
    settle();
    chk(audio_route, 8'h0f);
    @(posedge clk);
    tx_mode <= bridge_audio_clock_pkg::tx_dual;
    settle();
    chk(audio_route, 8'h0f);
    $display("t_audio done");
  endtask
  // 3d and dual-input bits, reserved bits, unmapped address
  task automatic t_bridge();
    logic [7:0] d;
    @(posedge clk);
    do_reset(1'b0);
    rd(8'h55, d);
    chk(d, 8'h00);
    rd(8'h56, d);
    chk(d, 8'h00);
    wr(8'h56, 8'hfc);
    rd(8'h56, d);
    chk(d, 8'hc0);
    settle();
    chk(sbs_3d, 8'h01);
    chk(dual_lr, 8'h01);
    wr(8'h00, 8'hff);
    rd(8'h00, d);
    chk(d, 8'h00);
    wr(8'h56, 8'h00);
    settle();
    chk(sbs_3d, 8'h00);
    chk(dual_lr, 8'h00);
    $display("t_bridge done");
  endtask
  // clock modes outside independent mode, transmit mode not splitter
  task automatic t_clk_modes();
    exp_src = '{8'h00, 8'h01, 8'h03};
    @(posedge clk);
    continuous_clock_set <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      wr(8'h56, 8'(i));
      settle();
      chk(port0_clk_src, exp_src[i]);
      chk(port1_clk_src, exp_src[i]);
      chk(clk_mode_error, 8'h00);
    end
    wr(8'h56, 8'h03);
    settle();
    chk(clk_mode_error, 8'h01);
    wr(8'h56, 8'h00);
    continuous_clock_set <= 1'b0;
    settle();
    chk(clk_mode_error, 8'h01);
    @(posedge clk);
    continuous_clock_set <= 1'b1;
    $display("t_clk_modes done");
  endtask
  // per-port clock mode in independent mode
  task automatic t_indep();
    logic [7:0] d;
    @(posedge clk);
    independent_mode <= 1'b1;
    selected_port    <= 1'b1;
    wr(8'h56, 8'h03);
    settle();
    chk(port1_clk_src, 8'h02);
    chk(port0_clk_src, 8'h00);
    chk(clk_mode_error, 8'h00);
    rd(8'h56, d);
    chk(d, 8'h03);
    @(posedge clk);
    selected_port <= 1'b0;
    wr(8'h56, 8'h03);
    settle();
    chk(port0_clk_src, 8'h01);
    wr(8'h56, 8'h02);
    settle();
    chk(port0_clk_src, 8'h03);
    chk(port1_clk_src, 8'h02);
    $display("t_indep done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    failures             = 0;
    compares             = 0;
    reset                = 1'b1;
    req                  = '0;
    mode_strap_pin       = 1'b0;
    tx_mode              = bridge_audio_clock_pkg::tx_single;
    independent_mode     = 1'b0;
    selected_port        = 1'b0;
    continuous_clock_set = 1'b1;
    t_audio();
    t_bridge();
    t_clk_modes();
    t_indep();
    close_out();
  end
  initial
  begin
    #(100 * 3000);
    failures++;
    close_out();
  end
endmodule
